// file: rctc_checker.sv
/* Assertions for rctc_top: chop link, fuse readback, gain source.
   Bound to rctc_top below; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module rctc_checker #(parameter logic [1:0] POS_CODE = 2'b01) (
  input wire logic                  CLK,
  input wire logic                  RESETN,
  input wire logic [15:0]           ADDR,
  input wire logic [31:0]           WDATA,
  input wire logic                  WR,
  input wire logic                  RD,
  input wire logic [31:0]           RDATA,
  input wire logic                  MUX_END,
  input wire logic [2:0]            SLOPE_FUSE,
  input wire rctc_pkg::rctc_cycle_s CYCLE,
  input wire logic                  GAIN_EXTERNAL
);
  import rctc_pkg::*;
  logic [1:0] mode, next_mode;
  logic [7:0] sel, next_sel;
  logic       pend, next_pend, cur_auto, next_cur_auto;
  wire logic  wc = WR && ADDR == ADDR_CHOP_CTRL;
  wire logic  is_auto = mode == 2'h0 || mode == 2'h3;
  // track mode, fuse index, pending alternate cycle, kind of running cycle
  always_comb begin
    next_mode = wc ? WDATA[5:4] : mode;
    next_sel = (WR && ADDR == ADDR_FUSE_SEL) ? WDATA[7:0] : sel;
    next_pend = (wc && WDATA[2]) || (pend && !MUX_END);
    next_cur_auto = MUX_END ? is_auto && !pend : cur_auto;
  end
  // register the tracked state
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {mode, sel, pend, cur_auto} <= '0;
    end else begin
      {mode, sel, pend, cur_auto} <= {next_mode, next_sel, next_pend, next_cur_auto};
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  property p_hold; !MUX_END |=> $stable(CYCLE); endproperty
  a_hold: assert property (p_hold) else $error("chop moved mid-cycle");
  property p_tog;
    MUX_END && is_auto && !pend && cur_auto |=> CYCLE.chop != $past(CYCLE.chop);
  endproperty
  a_tog: assert property (p_tog) else $error("auto chop did not toggle");
  property p_alt; MUX_END && is_auto && pend |=> CYCLE == 2'b01; endproperty
  a_alt: assert property (p_alt) else $error("alt cycle not positive");
  property p_fix;
    MUX_END && !is_auto |=> CYCLE == {$past(mode) != POS_CODE, $past(pend)};
  endproperty
  a_fix: assert property (p_fix) else $error("fixed code wrong polarity");
  property p_rd0; !RD |=> RDATA == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside read");
  property p_fuse;
    RD && ADDR == ADDR_FUSE_DATA && sel == FUSE_IDX_SLOPE |=> RDATA == {29'h0, SLOPE_FUSE};
  endproperty
  a_fuse: assert property (p_fuse) else $error("slope fuse readback wrong");
  property p_ext; WR && ADDR == ADDR_COMP_SRC && WDATA == SRC_EXTERNAL |=> ##[0:1] GAIN_EXTERNAL;
  endproperty
  a_ext: assert property (p_ext) else $error("external source not taken");
  property p_int; WR && ADDR == ADDR_COMP_SRC && WDATA == SRC_INTERNAL |=> ##[0:1] !GAIN_EXTERNAL;
  endproperty
  a_int: assert property (p_int) else $error("internal source not taken");
  c_alt: cover property (MUX_END && is_auto && pend);
  c_fix: cover property (MUX_END && !is_auto);
  c_fuse: cover property (RD && ADDR == ADDR_FUSE_DATA);
endmodule : rctc_checker
bind rctc_top rctc_checker #(.POS_CODE(POS_CODE)) u_rctc_checker (
  .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .MUX_END(MUX_END), .SLOPE_FUSE(SLOPE_FUSE), .CYCLE(CYCLE),
  .GAIN_EXTERNAL(GAIN_EXTERNAL));
`default_nettype wire

// file: rctc_pkg.sv
/*
  Package for the reference chop and temperature compensation control.
  Assumes a 16-bit register address and 32-bit register data.
*/
`default_nettype none
package rctc_pkg;
  // --------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------
  localparam logic [15:0] ADDR_COMPUTE_GAIN_ADJUST  = 16'h002e;
  localparam logic [15:0] ADDR_COMP_SRC  = 16'h0038;
  localparam logic [15:0] ADDR_LIN_COEF  = 16'h0039;
  localparam logic [15:0] ADDR_QUAD_COEF = 16'h003a;
  localparam logic [15:0] ADDR_REF_TEMP  = 16'h003b;
  localparam logic [15:0] ADDR_CHOP_CTRL = 16'h2002;
  localparam logic [15:0] ADDR_STATUS    = 16'h2003;
  localparam logic [15:0] ADDR_FUSE_SEL  = 16'h20fd;
  localparam logic [15:0] ADDR_FUSE_DATA = 16'h20ff;
  // --------------------------------------------------------------------
  // fields and values
  // --------------------------------------------------------------------
  localparam int          CTRL_MODE_LSB  = 4;
  localparam int          CTRL_ALT_BIT   = 2;
  localparam logic [31:0] SRC_INTERNAL   = 32'h0000_0000;
  localparam logic [31:0] SRC_EXTERNAL   = 32'h0000_000f;
  localparam logic [7:0]  FUSE_IDX_SLOPE = 8'h04;
  localparam logic [7:0]  FUSE_IDX_BGA   = 8'h05;
  localparam logic [7:0]  FUSE_IDX_BGB   = 8'h06;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam int          GAIN_SHIFT     = 14;
  // chop-mode codes; 00 and 11 both toggle
  typedef enum logic [1:0] {
    CM_AUTO_A = 2'b00,
    CM_FIX_01 = 2'b01,
    CM_FIX_10 = 2'b10,
    CM_AUTO_B = 2'b11
  } rctc_mode_e;
  // state shown to the converter for the current multiplexer cycle
  typedef struct packed {
    logic chop;
    logic alt;
  } rctc_cycle_s;
endpackage : rctc_pkg
`default_nettype wire

// file: rctc_top.sv
/*
  Reference amplifier chop control, compensation gain source selection
  and indexed fuse readback.
  Assumes MUX_END and TEMP_MEAS come from logic on CLK; fuse pins are
  static levels from outside and are synchronised here.
*/
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - chop output high reverses the reference amplifier input connection
// - chop polarity changes only at a multiplexer cycle boundary
// - chop-mode codes 00 and 11 both select automatic chopping
// - automatic mode inverts polarity on every successive regular cycle
// - alternate-cycle request inserts one alternate cycle between regular ones
// - in automatic mode the alternate cycle always runs positive
// - a mode written mid-cycle applies to the whole next cycle
// - source zero: engine computes gain adjust from coefficients and temperature
// - source fifteen: engine applies the firmware gain adjust value
// - write fuse index 4, 5 or 6, then read the fuse data
module rctc_top #(
  parameter logic [1:0] POS_CODE = 2'b01,
  parameter int         TW       = 16
) (
  input  wire logic              CLK,
  input  wire logic              RESETN,
  input  wire logic [15:0]       ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output var  logic [31:0]       RDATA,
  input  wire logic              MUX_END,
  input  wire logic [TW-1:0]     TEMP_MEAS,
  input  wire logic [2:0]        SLOPE_FUSE,
  input  wire logic [7:0]        BANDGAP_FUSE_A,
  input  wire logic [7:0]        BANDGAP_FUSE_B,
  output var  rctc_pkg::rctc_cycle_s CYCLE,
  output var  logic [31:0]       COMPUTE_GAIN_ADJUST,
  output var  logic              GAIN_EXTERNAL
);
  import rctc_pkg::*;

  // the register port is a plain single-cycle slave: a write lands at the
  // strobe edge and a read answers in the following cycle only, so RDATA
  // is zero whenever no read was made the cycle before
  // the chop link is updated only on the MUX_END pulse; between pulses
  // CYCLE is a stable level that the converter may sample at any time
  // fuse values are read through an index register, one fuse at a time

  // --------------------------------------------------------------------
  // reset release and fuse synchronisers
  // --------------------------------------------------------------------
  // reset release pair and the synchronised fuse word
  logic        rst_meta;
  logic        rst_n;
  logic [18:0] fuse_meta;
  logic [18:0] fuse_sync;

  // reset deasserts through two flops
  // assertion is immediate, release is aligned to CLK so that no register
  // leaves reset one edge before its neighbour
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // fuse levels pass two flops before use
  // the fuses are static after power-up; the pair only guards against a
  // level that settles late relative to the first clock edges
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      fuse_meta <= '0;
      fuse_sync <= '0;
    end else begin
      fuse_meta <= {SLOPE_FUSE, BANDGAP_FUSE_A, BANDGAP_FUSE_B};
      fuse_sync <= fuse_meta;
    end
  end

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  // programmable state and its next values
  rctc_mode_e  mode;
  rctc_mode_e  next_mode;
  logic        alt_req;
  logic        next_alt_req;
  logic [31:0] comp_src;
  logic [31:0] next_comp_src;
  logic [31:0] fw_gain;
  logic [31:0] next_fw_gain;
  logic [TW-1:0] lin_coef;
  logic [TW-1:0] next_lin_coef;
  logic [TW-1:0] quad_coef;
  logic [TW-1:0] next_quad_coef;
  logic [TW-1:0] ref_temp;
  logic [TW-1:0] next_ref_temp;
  logic [7:0]  fuse_sel;
  logic [7:0]  next_fuse_sel;
  logic [31:0] next_rdata;
  logic        alt_take;
  logic [7:0]  fuse_val;

  // fuse selected by index, unknown index reads zero
  // indices other than the three fuse slots read as zero so that stray
  // selector values never expose an undriven bus
  always_comb begin
    unique case (fuse_sel)
      FUSE_IDX_SLOPE: fuse_val = {5'h00, fuse_sync[18:16]};
      FUSE_IDX_BGA:   fuse_val = fuse_sync[15:8];
      FUSE_IDX_BGB:   fuse_val = fuse_sync[7:0];
      default:        fuse_val = 8'h00;
    endcase
  end

  // writes; the alternate request is consumed at a boundary, a new set wins
  // a mode write only changes the register; the chop output picks it up at
  // the next MUX_END, so a write in mid-cycle never moves the running cycle
  // a set of the alternate request in the same cycle as its consumption
  // is kept, so a request made late is not lost
  always_comb begin
    next_mode      = mode;
    next_alt_req   = alt_req & ~alt_take;
    next_comp_src  = comp_src;
    next_fw_gain   = fw_gain;
    next_lin_coef  = lin_coef;
    next_quad_coef = quad_coef;
    next_ref_temp  = ref_temp;
    next_fuse_sel  = fuse_sel;
    if (WR) begin
      unique case (ADDR)
        ADDR_CHOP_CTRL: begin
          next_mode = rctc_mode_e'(WDATA[CTRL_MODE_LSB +: 2]);
          if (WDATA[CTRL_ALT_BIT]) begin
            next_alt_req = 1'b1;
          end
        end
        ADDR_COMP_SRC:  next_comp_src = WDATA;
        ADDR_COMPUTE_GAIN_ADJUST:  next_fw_gain = WDATA;
        ADDR_LIN_COEF:  next_lin_coef = WDATA[TW-1:0];
        ADDR_QUAD_COEF: next_quad_coef = WDATA[TW-1:0];
        ADDR_REF_TEMP:  next_ref_temp = WDATA[TW-1:0];
        ADDR_FUSE_SEL:  next_fuse_sel = WDATA[7:0];
        default: ;
      endcase
    end
  end

  // read data for the cycle after the strobe; unmapped reads zero
  // reading the gain register returns the value actually applied, which is
  // the computed value in source 0 and the firmware value in source 15
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (RD) begin
      unique case (ADDR)
        ADDR_CHOP_CTRL: next_rdata = {26'h0, mode, 1'b0, alt_req, 2'h0};
        ADDR_STATUS:    next_rdata = {29'h0, GAIN_EXTERNAL, CYCLE};
        ADDR_COMP_SRC:  next_rdata = comp_src;
        ADDR_COMPUTE_GAIN_ADJUST:  next_rdata = COMPUTE_GAIN_ADJUST;
        ADDR_LIN_COEF:  next_rdata = 32'(lin_coef);
        ADDR_QUAD_COEF: next_rdata = 32'(quad_coef);
        ADDR_REF_TEMP:  next_rdata = 32'(ref_temp);
        ADDR_FUSE_SEL:  next_rdata = {24'h0, fuse_sel};
        ADDR_FUSE_DATA: next_rdata = {24'h0, fuse_val};
        default: ;
      endcase
    end
  end

  // register file flops
  // RDATA is cleared every cycle without a read
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= rctc_mode_e'(MODE_RESET);
      alt_req   <= 1'b0;
      comp_src  <= SRC_INTERNAL;
      fw_gain   <= '0;
      lin_coef  <= '0;
      quad_coef <= '0;
      ref_temp  <= '0;
      fuse_sel  <= '0;
      RDATA     <= '0;
    end else begin
      mode      <= next_mode;
      alt_req   <= next_alt_req;
      comp_src  <= next_comp_src;
      fw_gain   <= next_fw_gain;
      lin_coef  <= next_lin_coef;
      quad_coef <= next_quad_coef;
      ref_temp  <= next_ref_temp;
      fuse_sel  <= next_fuse_sel;
      RDATA     <= next_rdata;
    end
  end

  // --------------------------------------------------------------------
  // chop sequencing
  // --------------------------------------------------------------------
  // toggle remembers the polarity of the last regular automatic cycle
  logic        toggle;
  logic        next_toggle;
  rctc_cycle_s next_cycle;
  logic        is_auto;

  // automatic-mode decode and consumption of the alternate request
  assign is_auto  = (mode == CM_AUTO_A) || (mode == CM_AUTO_B);
  assign alt_take = MUX_END & alt_req;

  // next cycle's polarity is decided only on a cycle boundary
  // in automatic mode an alternate cycle is forced positive and does not
  // advance the toggle, so regular cycles keep alternating around it
  // fixed codes ignore the toggle; POS_CODE names the code that gives the
  // positive connection, the other fixed code gives the reversed one
  always_comb begin
    next_toggle = toggle;
    next_cycle  = CYCLE;
    if (MUX_END) begin
      next_cycle.alt = alt_req;
      if (is_auto) begin
        if (alt_req) begin
          next_cycle.chop = 1'b0;
        end else begin
          next_toggle     = ~toggle;
          next_cycle.chop = ~toggle;
        end
      end else begin
        next_cycle.chop = (mode != rctc_mode_e'(POS_CODE));
      end
    end
  end

  // chop state flops
  // CYCLE and the toggle reset to positive with no alternate cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      toggle <= 1'b0;
      CYCLE  <= '0;
    end else begin
      toggle <= next_toggle;
      CYCLE  <= next_cycle;
    end
  end

  // --------------------------------------------------------------------
  // gain adjust source
  // --------------------------------------------------------------------
  // signed working widths for the temperature polynomial
  logic signed [TW:0]     dt;
  logic signed [2*TW+1:0] dt_sq;
  logic signed [3*TW+2:0] lin_term;
  logic signed [3*TW+2:0] quad_term;
  logic signed [3*TW+2:0] sum_term;
  logic [31:0]            next_gain;
  logic                   next_ext;

  // polynomial in the temperature offset from the reference
  // the linear term is scaled up by GAIN_SHIFT so both terms share one
  // binary point before the final arithmetic shift; the sum is wide enough
  // that no intermediate product wraps for full-range inputs
  // the result is cut to 32 bits on purpose, as the gain register is
  always_comb begin
    dt        = $signed({TEMP_MEAS[TW-1], TEMP_MEAS}) - $signed({ref_temp[TW-1], ref_temp});
    dt_sq     = dt * dt;
    lin_term  = (3*TW+3)'($signed(lin_coef) * dt) <<< GAIN_SHIFT;
    quad_term = (3*TW+3)'($signed(quad_coef) * dt_sq);
    sum_term  = (lin_term + quad_term) >>> (2 * GAIN_SHIFT);
  end

  // source 0 computes, source 15 passes firmware value, others hold
  // any other source value freezes COMPUTE_GAIN_ADJUST and GAIN_EXTERNAL, so firmware
  // can switch sources without a glitch through an unintended value
  always_comb begin
    next_gain = COMPUTE_GAIN_ADJUST;
    next_ext  = GAIN_EXTERNAL;
    if (comp_src == SRC_INTERNAL) begin
      next_gain = sum_term[31:0];
      next_ext  = 1'b0;
    end else if (comp_src == SRC_EXTERNAL) begin
      next_gain = fw_gain;
      next_ext  = 1'b1;
    end
  end

  // gain flops
  // gain output lags the selected source by one cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      COMPUTE_GAIN_ADJUST      <= '0;
      GAIN_EXTERNAL <= 1'b0;
    end else begin
      COMPUTE_GAIN_ADJUST      <= next_gain;
      GAIN_EXTERNAL <= next_ext;
    end
  end
endmodule : rctc_top
`default_nettype wire

// file: tb_reference_chop_temp_comp_control.sv
/* Bench for rctc_top: register port, chop link, gain source, fuses.
   Needs rctc_pkg and rctc_checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_reference_chop_temp_comp_control;
  import rctc_pkg::*;
  localparam logic [1:0] POS = 2'b01;
  logic        clk, resetn, wr, rd, mux_end, ext;
  logic [15:0] addr, temp;
  logic [31:0] wdata, rdata, gain, g;
  logic [31:0] fx [4];
  logic [2:0]  fs;
  logic [7:0]  fa, fb;
  logic [1:0]  last;
  rctc_cycle_s cyc;
  int          err_total = 0, samples_checked = 0, tog = 0, pend = 0, mode = 0;
  rctc_top #(.POS_CODE(POS)) u_rctc_top (.CLK(clk), .RESETN(resetn), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .MUX_END(mux_end),
    .TEMP_MEAS(temp), .SLOPE_FUSE(fs), .BANDGAP_FUSE_A(fa), .BANDGAP_FUSE_B(fb),
    .CYCLE(cyc), .COMPUTE_GAIN_ADJUST(gain), .GAIN_EXTERNAL(ext));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  // one-cycle write, then an idle cycle
  task automatic wrt(input logic [15:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wrt
  // read, data sampled in the cycle after the strobe
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    @(posedge clk);
  endtask : rdc
  // chop control write; the running cycle must not move
  task automatic setm(input logic [1:0] m, input logic a);
    wrt(ADDR_CHOP_CTRL, {26'h0, m, 1'b0, a, 2'h0});
    mode = m;
    pend = pend | a;
    chk("hold", {30'h0, last}, {30'h0, cyc});
  endtask : setm
  // one multiplexer boundary against the model
  task automatic mux();
    if (mode == 1 || mode == 2) begin
      last = {2'(mode) != POS, pend[0]};
    end else if (pend != 0) begin
      last = 2'b01;
    end else begin
      tog = 1 - tog;
      last = {tog[0], 1'b0};
    end
    pend = 0;
    mux_end <= 1'b1;
    @(posedge clk);
    mux_end <= 1'b0;
    #1 chk("cycle", {30'h0, last}, {30'h0, cyc});
    @(posedge clk);
  endtask : mux
  // counts, verdict, end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // hang guard
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize();
  end
  // main sequence
  initial begin
    {resetn, wr, rd, mux_end, addr, wdata, temp, last} = '0;
    void'($urandom(23));
    {fs, fa, fb} = 19'($urandom);
    fx = '{{29'h0, fs}, {24'h0, fa}, {24'h0, fb}, 32'h0};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(ADDR_CHOP_CTRL, 32'h0);
    rdc(ADDR_COMP_SRC, SRC_INTERNAL);
    wrt(16'h1234, 32'hffff_ffff);
    rdc(16'h1234, 32'h0);
    $display("test reset values done");
    repeat (3) mux();
    setm(2'h3, 1'b0);
    repeat (2) mux();
    setm(2'h3, 1'b1);
    rdc(ADDR_CHOP_CTRL, {26'h0, 2'h3, 1'b0, 1'b1, 2'h0});
    repeat (3) mux();
    $display("test automatic chop done");
    for (int i = 1; i < 3; i++) begin
      setm(2'(3 - i), 1'b1);
      repeat (2) mux();
    end
    setm(2'h3, 1'b0);
    $display("test fixed chop done");
    wrt(ADDR_COMP_SRC, SRC_EXTERNAL);
    g = $urandom;
    wrt(ADDR_COMPUTE_GAIN_ADJUST, g);
    @(negedge clk);
    chk("gain", g, gain);
    chk("ext", 32'h1, {31'h0, ext});
    @(posedge clk);
    rdc(ADDR_STATUS, {29'h0, 1'b1, last});
    wrt(ADDR_COMP_SRC, 32'h5);
    temp <= 16'h3;
    rdc(ADDR_COMPUTE_GAIN_ADJUST, g);
    wrt(ADDR_LIN_COEF, 32'h4000);
    wrt(ADDR_QUAD_COEF, 32'h0);
    wrt(ADDR_REF_TEMP, 32'h4);
    rdc(ADDR_REF_TEMP, 32'h4);
    wrt(ADDR_COMP_SRC, SRC_INTERNAL);
    repeat (4) begin
      temp <= 16'($urandom_range(7));
      repeat (3) @(negedge clk);
      chk("gain_int", 32'(int'(temp) - 4), gain);
      @(posedge clk);
    end
    chk("ext", 32'h0, {31'h0, ext});
    $display("test gain source done");
    for (int i = 0; i < 4; i++) begin
      wrt(ADDR_FUSE_SEL, 32'(i + 4));
      rdc(ADDR_FUSE_DATA, fx[i]);
      rdc(ADDR_FUSE_SEL, 32'(i + 4));
    end
    $display("test fuses done");
    summarize();
  end
endmodule : tb_reference_chop_temp_comp_control
`default_nettype wire
